/* File: epec_pkg.sv */
package epec_pkg;

  //----------------------------------------------------------------
  // Register indices, byte address is four times the index
  //----------------------------------------------------------------
  localparam logic [7:0]  IDX_DIV_HIGH    = 8'hEE;
  localparam logic [7:0]  IDX_DIV_LOW     = 8'hEF;
  localparam logic [7:0]  IDX_CONFIG      = 8'hF0;
  localparam logic [7:0]  IDX_PROTECT     = 8'hF1;
  localparam logic [7:0]  IDX_CONTROL     = 8'hF3;
  localparam logic [7:0]  IDX_STATUS      = 8'hF4;
  localparam logic [7:0]  IDX_ARRAY_WRITE = 8'hF8;
  localparam int          ADDR_W          = 10;

  //----------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------
  localparam int CFG_DEBUG     = 7;
  localparam int CFG_HIDE      = 6;
  localparam int CFG_WAITSTOP  = 2;
  localparam int CFG_LOCK      = 1;
  localparam int CFG_SPARE     = 0;
  localparam int PROT_SHADOW   = 7;
  localparam int CTL_BULK_ERASE_PROTECT     = 7;
  localparam int CTL_AUTO      = 5;
  localparam int CTL_BYTE      = 4;
  localparam int CTL_ROW       = 3;
  localparam int CTL_ERASE     = 2;
  localparam int CTL_LATCH     = 1;
  localparam int CTL_PGM       = 0;
  localparam int ARR_ADDR_LSB  = 16;

  //----------------------------------------------------------------
  // Reset values
  //----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET  = 8'h0C;
  localparam logic [7:0] PROTECT_RESET = 8'hBF;
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  //----------------------------------------------------------------
  // Array map
  //----------------------------------------------------------------
  localparam logic [11:0] SHADOW_ADDR = 12'hFC0;
  localparam logic [5:0][11:0] REGION_BASE = {12'h800, 12'hC00, 12'hE00,
                                              12'hF00, 12'hF80, 12'hFC0};
  localparam logic [5:0][11:0] REGION_MASK = {12'hC00, 12'hE00, 12'hF00,
                                              12'hF80, 12'hFC0, 12'hFC0};

  //----------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------
  localparam int PROG_TIME_US  = 10000;
  localparam int PULSE_TIME_US = 35;
  localparam int PULSE_COUNT   = (PROG_TIME_US + PULSE_TIME_US - 1) / PULSE_TIME_US;

  typedef enum logic [1:0] {
    OP_PROGRAM = 2'b00,
    OP_BULK    = 2'b01,
    OP_ROW     = 2'b10,
    OP_BYTE    = 2'b11
  } epec_op_t;

endpackage : epec_pkg

/* File: epec_self_timer.sv */
`timescale 1ns/100ps
module epec_self_timer import epec_pkg::*; (
  input  wire logic       ref_clk,  // Bus clock
  input  wire logic       reset,    // Synchronous reset
  input  wire logic       run,      // Cycle under way
  input  wire logic [9:0] divider,  // Self-time divider
  output logic            done      // One-cycle end of cycle
);

  logic [9:0] divCntQ;
  logic [8:0] pulseCntQ;
  logic       expiredQ;

  wire        tick    = (divCntQ + 10'h001) >= divider;
  wire        lastOne = pulseCntQ == 9'(PULSE_COUNT - 1);

  //----------------------------------------------------------------
  // Prescaler and pulse counter
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      divCntQ   <= 10'h000;
      pulseCntQ <= 9'h000;
      expiredQ  <= 1'b0;
      done      <= 1'b0;
    end else begin
      divCntQ <= tick ? 10'h000 : divCntQ + 10'h001;
      done    <= 1'b0;
      if (tick && !expiredQ) begin
        pulseCntQ <= pulseCntQ + 9'h001;
        if (lastOne) begin
          expiredQ <= 1'b1;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule : epec_self_timer

/* File: epec_top.sv */
`timescale 1ns/100ps
module epec_top import epec_pkg::*; (
  input  wire logic              ref_clk,         // Bus clock, 20 MHz
  input  wire logic              reset,           // Synchronous reset, high
  input  wire logic              specialModeN,    // Mode pin, low selects special
  input  wire logic [15:0]       shadowWord,      // Shadow word from the array
  input  wire logic              awvalid,         // Write address valid
  output logic                   awready,         // Write address ready
  input  wire logic [ADDR_W-1:0] awaddr,          // Write byte address
  input  wire logic              wvalid,          // Write data valid
  output logic                   wready,          // Write data ready
  input  wire logic [31:0]       wdata,           // Write data
  input  wire logic [3:0]        wstrb,           // Write byte strobes
  output logic                   bvalid,          // Write response valid
  input  wire logic              bready,          // Write response ready
  output logic [1:0]             bresp,           // Write response
  input  wire logic              arvalid,         // Read address valid
  output logic                   arready,         // Read address ready
  input  wire logic [ADDR_W-1:0] araddr,          // Read byte address
  output logic                   rvalid,          // Read data valid
  input  wire logic              rready,          // Read data ready
  output logic [31:0]            rdata,           // Read data
  output logic [1:0]             rresp,           // Read response
  output logic                   hvEnable,        // Array voltage on
  output epec_op_t               arrayOp,         // Program or erase size
  output logic [11:0]            latchAddr,       // Latched array address
  output logic [15:0]            latchData,       // Latched array data
  output logic                   latchWord,       // Latched access is a word
  output logic                   latchActive,     // Latches set up for a cycle
  output logic                   shadowSelect     // Latched address hits shadow
);

  function automatic logic [5:0] region_hit(input logic [11:0] addr);
    logic [5:0] hit;
    hit = 6'h00;
    for (int i = 0; i < 6; i++) begin
      hit[i] = (addr & REGION_MASK[i]) == REGION_BASE[i];
    end
    return hit;
  endfunction : region_hit

  function automatic logic map_hit(input logic [7:0] idx);
    return idx == IDX_DIV_HIGH || idx == IDX_DIV_LOW || idx == IDX_CONFIG ||
           idx == IDX_PROTECT || idx == IDX_CONTROL || idx == IDX_STATUS ||
           idx == IDX_ARRAY_WRITE;
  endfunction : map_hit

  logic              modeMetaQ;
  logic              modeSyncQ;
  logic              loadPendQ;
  logic              awHaveQ;
  logic              wHaveQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0]       wDataQ;
  logic [3:0]        wStrbQ;
  logic [7:0]        configQ;
  logic [7:0]        protectQ;
  logic [7:0]        controlQ;
  logic [1:0]        divHighQ;
  logic [7:0]        divLowQ;
  logic              divHighDoneQ;
  logic              divLowDoneQ;
  logic              lockDoneQ;
  logic              latchLoadedQ;
  logic              blockedQ;
  logic              timerDone;

  //----------------------------------------------------------------
  // Decode
  //----------------------------------------------------------------
  wire        special    = ~modeSyncQ;
  wire        wrFire     = awHaveQ & wHaveQ & ~bvalid;
  wire [7:0]  wrIdx      = awAddrQ[ADDR_W-1:2];
  wire [7:0]  rdIdx      = araddr[ADDR_W-1:2];
  wire [7:0]  wByte      = wDataQ[7:0];
  wire        wrLow      = wrFire & wStrbQ[0];
  wire        wrCfg      = wrLow & (wrIdx == IDX_CONFIG);
  wire        wrProt     = wrLow & (wrIdx == IDX_PROTECT);
  wire        wrCtl      = wrLow & (wrIdx == IDX_CONTROL);
  wire        wrDivH     = wrLow & (wrIdx == IDX_DIV_HIGH);
  wire        wrDivL     = wrLow & (wrIdx == IDX_DIV_LOW);
  wire        wrArr      = wrFire & (wrIdx == IDX_ARRAY_WRITE);
  wire        pgmOn      = controlQ[CTL_PGM];
  wire        latchOn    = controlQ[CTL_LATCH];
  wire        lockOn     = configQ[CFG_LOCK];
  wire        divNonZero = {divHighQ, divLowQ} != 10'h000;
  wire        protOk     = wrProt & ~pgmOn & ~lockOn;
  wire        lockOk     = wrCfg & (special | ~lockDoneQ);
  wire        divHOk     = wrDivH & ~latchOn & (special | ~divHighDoneQ);
  wire        divLOk     = wrDivL & ~latchOn & (special | ~divLowDoneQ);
  wire        modeOk     = wrCtl & ~pgmOn;
  wire        latchOk    = modeOk & divNonZero;
  wire        pgmSet     = modeOk & latchOn & wByte[CTL_LATCH] & wByte[CTL_PGM]
                           & divNonZero;
  wire        pgmClr     = (wrCtl & pgmOn & ~wByte[CTL_PGM]) | timerDone;
  wire        arrLoadOk  = wrArr & latchOn & ~pgmOn;
  wire [11:0] arrAddrIn  = wDataQ[ARR_ADDR_LSB +: 12];

  //----------------------------------------------------------------
  // Cycle refusal and operation
  //----------------------------------------------------------------
  wire       eraseOn    = controlQ[CTL_ERASE];
  wire       shadowHit  = ~configQ[CFG_HIDE] &
                          (latchAddr[11:1] == SHADOW_ADDR[11:1]);
  wire       shadowBad  = shadowHit & protectQ[PROT_SHADOW];
  wire       regionBad  = |(region_hit(latchAddr) & protectQ[5:0]) & ~shadowHit;
  epec_op_t  opNext;
  assign opNext = !eraseOn              ? OP_PROGRAM :
                  controlQ[CTL_BYTE]    ? OP_BYTE    :
                  controlQ[CTL_ROW]     ? OP_ROW     : OP_BULK;
  wire       bulkBad    = controlQ[CTL_BULK_ERASE_PROTECT] &
                          (opNext == OP_BULK || opNext == OP_ROW);
  wire       refuse     = shadowBad | bulkBad |
                          ((opNext != OP_BULK) & regionBad);

  //----------------------------------------------------------------
  // Read mux
  //----------------------------------------------------------------
  wire [7:0] statusWord = {3'h0, hvEnable, latchLoadedQ, special, ~loadPendQ, blockedQ};
  wire [7:0] readByte   = rdIdx == IDX_DIV_HIGH ? {6'h00, divHighQ} :
                          rdIdx == IDX_DIV_LOW  ? divLowQ  :
                          rdIdx == IDX_CONFIG   ? configQ  :
                          rdIdx == IDX_PROTECT  ? protectQ :
                          rdIdx == IDX_CONTROL  ? controlQ :
                          rdIdx == IDX_STATUS   ? statusWord : 8'h00;

  //----------------------------------------------------------------
  // Mode pin synchroniser and shadow load
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      modeMetaQ <= 1'b1;
      modeSyncQ <= 1'b1;
      loadPendQ <= 1'b1;
    end else begin
      modeMetaQ <= specialModeN;
      modeSyncQ <= modeMetaQ;
      loadPendQ <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // AXI4-Lite write channels
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      awHaveQ <= 1'b0;
      awready <= 1'b1;
      awAddrQ <= '0;
    end else if (awvalid && awready) begin
      awHaveQ <= 1'b1;
      awready <= 1'b0;
      awAddrQ <= awaddr;
    end else if (bvalid && bready) begin
      awHaveQ <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wHaveQ <= 1'b0;
      wready <= 1'b1;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else if (wvalid && wready) begin
      wHaveQ <= 1'b1;
      wready <= 1'b0;
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end else if (bvalid && bready) begin
      wHaveQ <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= map_hit(wrIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // AXI4-Lite read channels
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, readByte};
      rresp   <= map_hit(rdIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Configuration and divider
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      configQ   <= CONFIG_RESET;
      lockDoneQ <= 1'b0;
    end else begin
      if (loadPendQ) begin
        configQ[7:4] <= shadowWord[15:12];
      end else if (wrCfg && special) begin
        configQ[7:4] <= wByte[7:4];
      end
      if (wrCfg) begin
        configQ[CFG_WAITSTOP] <= wByte[CFG_WAITSTOP];
        configQ[CFG_SPARE]    <= wByte[CFG_SPARE];
      end
      if (lockOk) begin
        configQ[CFG_LOCK] <= wByte[CFG_LOCK];
        lockDoneQ         <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divHighQ     <= 2'h0;
      divLowQ      <= 8'h00;
      divHighDoneQ <= 1'b0;
      divLowDoneQ  <= 1'b0;
    end else if (loadPendQ) begin
      divHighQ <= shadowWord[9:8];
      divLowQ  <= shadowWord[7:0];
    end else begin
      if (divHOk) begin
        divHighQ     <= wByte[1:0];
        divHighDoneQ <= 1'b1;
      end
      if (divLOk) begin
        divLowQ     <= wByte;
        divLowDoneQ <= 1'b1;
      end
    end
  end

  //----------------------------------------------------------------
  // Protection and control registers
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      protectQ <= PROTECT_RESET;
    end else if (protOk) begin
      protectQ <= {wByte[PROT_SHADOW], 1'b0, wByte[5:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      controlQ <= CONTROL_RESET;
    end else begin
      if (modeOk) begin
        if (!lockOn) begin
          controlQ[CTL_BULK_ERASE_PROTECT] <= wByte[CTL_BULK_ERASE_PROTECT];
        end
        controlQ[CTL_AUTO]  <= wByte[CTL_AUTO];
        controlQ[CTL_BYTE]  <= wByte[CTL_BYTE];
        controlQ[CTL_ROW]   <= wByte[CTL_ROW];
        controlQ[CTL_ERASE] <= wByte[CTL_ERASE];
      end
      if (latchOk) begin
        controlQ[CTL_LATCH] <= wByte[CTL_LATCH];
      end
      if (pgmClr) begin
        controlQ[CTL_PGM] <= 1'b0;
      end else if (pgmSet) begin
        controlQ[CTL_PGM] <= 1'b1;
      end
    end
  end

  //----------------------------------------------------------------
  // Latches and array drive
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || !latchOn) begin
      latchAddr    <= 12'h000;
      latchData    <= 16'h0000;
      latchWord    <= 1'b0;
      latchLoadedQ <= 1'b0;
    end else if (arrLoadOk) begin
      latchAddr    <= latchWordIn(arrAddrIn, &wStrbQ[1:0]);
      latchData    <= wDataQ[15:0];
      latchWord    <= &wStrbQ[1:0];
      latchLoadedQ <= 1'b1;
    end
  end

  function automatic logic [11:0] latchWordIn(input logic [11:0] a, input logic word);
    return word ? {a[11:1], 1'b0} : a;
  endfunction : latchWordIn

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blockedQ     <= 1'b0;
      hvEnable     <= 1'b0;
      arrayOp      <= OP_PROGRAM;
      latchActive  <= 1'b0;
      shadowSelect <= 1'b0;
    end else begin
      if (pgmSet) begin
        blockedQ <= refuse;
      end
      hvEnable     <= pgmOn & ~pgmClr & ~blockedQ;
      arrayOp      <= opNext;
      latchActive  <= latchOn;
      shadowSelect <= shadowHit;
    end
  end

  //----------------------------------------------------------------
  // Self-terminate timer
  //----------------------------------------------------------------
  epec_self_timer u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (pgmOn & controlQ[CTL_AUTO]),
    .divider ({divHighQ, divLowQ}),
    .done    (timerDone)
  );

endmodule : epec_top

/* File: epec_properties.sv */
`timescale 1ns/100ps
module epec_checker import epec_pkg::*; (
  input wire logic        ref_clk,     // Clock
  input wire logic        reset,       // Reset
  input wire logic        awvalid,     // Bus
  input wire logic        awready,     // Bus
  input wire logic        wvalid,      // Bus
  input wire logic        wready,      // Bus
  input wire logic        bvalid,      // Bus
  input wire logic        bready,      // Bus
  input wire logic [1:0]  bresp,       // Bus
  input wire logic        arvalid,     // Bus
  input wire logic        arready,     // Bus
  input wire logic        rvalid,      // Bus
  input wire logic        rready,      // Bus
  input wire logic [31:0] rdata,       // Bus
  input wire logic        hvEnable,    // Voltage on
  input wire epec_op_t    arrayOp,     // Cycle kind
  input wire logic [11:0] latchAddr,   // Latched address
  input wire logic [15:0] latchData,   // Latched data
  input wire logic        latchActive  // Latches armed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
  sequence s_wr_ans; !bvalid ##1 bvalid; endsequence
  property p_wr_answer; s_wr_take |=> s_wr_ans; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer mistimed");
  property p_rd_answer; arvalid && arready |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ready_low; bvalid |-> !awready && !wready; endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready during response");
  property p_hv_latch; hvEnable |-> latchActive && $past(latchActive); endproperty
  a_hv_latch: assert property (p_hv_latch) else $error("voltage without latch");
  property p_frozen;
    hvEnable && $past(hvEnable) |->
      $stable(latchAddr) && $stable(latchData) && $stable(arrayOp);
  endproperty
  a_frozen: assert property (p_frozen) else $error("latches moved under voltage");
  property p_reset_idle; $fell(reset) |-> !hvEnable && !latchActive && !bvalid; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule : epec_checker
bind epec_top epec_checker u_checker (.ref_clk, .reset, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .hvEnable, .arrayOp, .latchAddr, .latchData, .latchActive);

/* File: test_eeprom_program_erase_control.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_eeprom_program_erase_control;
  import epec_pkg::*;
  logic ref_clk, reset, specialModeN, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hvEnable, latchWord, latchActive, shadowSelect;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rv;
  logic [15:0]       shadowWord, latchData;
  logic [11:0]       latchAddr;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, resp;
  epec_op_t          arrayOp;
  int                failures = 0, checkCount = 0;
  epec_top dut (.ref_clk, .reset, .specialModeN, .shadowWord, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .hvEnable, .arrayOp, .latchAddr, .latchData,
    .latchWord, .latchActive, .shadowSelect);
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  //------------------------------
  // Bus tasks
  //------------------------------
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [3:0] s = 4'h1);
    @(posedge ref_clk);
    awaddr <= {i, 2'h0}; wdata <= d; wstrb <= s;
    awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] i);
    @(posedge ref_clk);
    araddr <= {i, 2'h0}; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rv = rdata; resp = rresp;
    rready <= 1'h0;
  endtask : rd
  task automatic ck(input string n, input logic [7:0] i, input logic [7:0] e);
    rd(i);
    `CHK(n, e, rv[7:0])
  endtask : ck
  //------------------------------
  // Scenarios
  //------------------------------
  task automatic t_reset;
    ck("control", IDX_CONTROL, CONTROL_RESET);
    ck("protect", IDX_PROTECT, PROTECT_RESET);
    ck("config", IDX_CONFIG, 8'hFC);
    ck("divlow", IDX_DIV_LOW, 8'h00);
    rd(8'hF2);
    `CHK("unmapped", RESP_SLVERR, resp)
    wr(8'hF2, 32'h0000_00FF);
    `CHK("wrUnmapped", RESP_SLVERR, resp)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_div;
    wr(IDX_CONTROL, 32'h82);
    ck("latch", IDX_CONTROL, 8'h80);
    wr(IDX_DIV_LOW, 32'h01);
    wr(IDX_DIV_LOW, 32'h05);
    ck("divider", IDX_DIV_LOW, 8'h01);
    $display("t_div done");
  endtask : t_div
  task automatic t_refuse;
    logic [7:0] c;
    for (int k = 0; k < 7; k++) begin
      c = (k == 6) ? 8'h86 : 8'h82;
      wr(IDX_CONTROL, {24'h0, c});
      wr(IDX_ARRAY_WRITE, {4'h0, REGION_BASE[k % 6], 16'h1234}, 4'h3);
      wr(IDX_CONTROL, {24'h0, c | 8'h01});
      @(negedge ref_clk);
      `CHK("hvEnable", 1'h0, hvEnable)
      rd(IDX_STATUS);
      `CHK("refused", 1'h1, rv[0])
      wr(IDX_CONTROL, {24'h0, c});
    end
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_lock;
    wr(IDX_PROTECT, 32'h00);
    ck("protect", IDX_PROTECT, 8'h00);
    wr(IDX_CONTROL, 32'h00);
    ck("bulk_erase_protect", IDX_CONTROL, 8'h00);
    wr(IDX_CONFIG, 32'h02);
    wr(IDX_CONFIG, 32'h01);
    ck("lock", IDX_CONFIG, 8'hFB);
    wr(IDX_PROTECT, 32'h3F);
    ck("protect", IDX_PROTECT, 8'h00);
    wr(IDX_CONTROL, 32'h80);
    ck("bulk_erase_protect", IDX_CONTROL, 8'h00);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_cycle;
    wr(IDX_CONTROL, 32'h03);
    ck("joint", IDX_CONTROL, 8'h02);
    wr(IDX_ARRAY_WRITE, 32'h00A1BEEF, 4'h3);
    @(negedge ref_clk);
    `CHK("addr", 12'h0A0, latchAddr)
    `CHK("word", 1'h1, latchWord)
    wr(IDX_CONTROL, 32'h03);
    @(negedge ref_clk);
    `CHK("hvOn", 1'h1, hvEnable)
    wr(IDX_CONTROL, 32'h3F);
    wr(IDX_ARRAY_WRITE, 32'h00100000);
    ck("frozen", IDX_CONTROL, 8'h03);
    `CHK("data", 16'hBEEF, latchData)
    wr(IDX_CONTROL, 32'h02);
    @(negedge ref_clk);
    `CHK("hvOff", 1'h0, hvEnable)
    wr(IDX_CONTROL, 32'h00);
    $display("t_cycle done");
  endtask : t_cycle
  task automatic t_auto;
    logic [7:0] c [6] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h1C, 8'h18};
    epec_op_t o [6] = '{OP_PROGRAM, OP_BULK, OP_ROW, OP_BYTE, OP_BYTE, OP_PROGRAM};
    int n;
    foreach (c[k]) begin
      wr(IDX_CONTROL, {24'h0, c[k] | 8'h22});
      wr(IDX_ARRAY_WRITE, 32'h00A00055);
      wr(IDX_CONTROL, {24'h0, c[k] | 8'h23});
      @(negedge ref_clk);
      `CHK("op", o[k], arrayOp)
      n = 0;
      while (hvEnable) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK("selfTime", 1'h1, n inside {[280:292]})
      rd(IDX_CONTROL);
      `CHK("pgmClear", 1'h0, rv[0])
    end
    wr(IDX_CONTROL, 32'h00);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_special;
    reset <= 1'h1;
    specialModeN <= 1'h0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (3) @(posedge ref_clk);
    wr(IDX_DIV_LOW, 32'h02);
    wr(IDX_DIV_LOW, 32'h01);
    ck("divSpecial", IDX_DIV_LOW, 8'h01);
    wr(IDX_CONFIG, 32'hB2);
    wr(IDX_CONFIG, 32'hB0);
    ck("lockSpecial", IDX_CONFIG, 8'hB8);
    wr(IDX_CONTROL, 32'h82);
    wr(IDX_ARRAY_WRITE, {4'h0, SHADOW_ADDR, 16'hFC01}, 4'h3);
    @(negedge ref_clk);
    `CHK("shadowSel", 1'h1, shadowSelect)
    wr(IDX_CONTROL, 32'h83);
    rd(IDX_STATUS);
    `CHK("shadowProt", 8'h0F, rv[7:0])
    wr(IDX_CONTROL, 32'h82);
    wr(IDX_PROTECT, 32'h3F);
    wr(IDX_CONTROL, 32'h83);
    @(negedge ref_clk);
    `CHK("shadowPgm", 1'h1, hvEnable)
    wr(IDX_CONTROL, 32'h82);
    wr(IDX_CONTROL, 32'h80);
    wr(IDX_PROTECT, 32'hBF);
    ck("reprotect", IDX_PROTECT, 8'hBF);
    $display("t_special done");
  endtask : t_special
  task automatic conclude;
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    conclude();
  end
  initial begin
    reset = 1'h1; specialModeN = 1'h1;
    shadowWord = 16'hFC00;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0; rready = 1'h0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (3) @(posedge ref_clk);
    t_reset(); t_div(); t_refuse(); t_lock(); t_cycle(); t_auto(); t_special();
    conclude();
  end
endmodule : test_eeprom_program_erase_control
